/* src/tcu_timer_regs.vh */
/*
 Register map, field positions, reset values and timing counts of the
 16-bit up/down reload timer with clock output.
 Assumes an APB slave with 32-bit data and byte addresses.
*/
// What this block does
// RULE1 - 16-bit count in two cascaded byte halves.
// RULE2 - Counter select picks clock/12 or pin.
// RULE3 - Count advances only while run bit set.
// RULE4 - Capture, reload, baud modes from control bits.
// RULE5 - Up/down enable makes direction pin steer count.
// RULE6 - Up overflow sets flag, interrupts, reloads.
// RULE7 - Down at reload value: flag, load FFFFh.
// RULE8 - External flag toggles, no interrupt, 17 bits.
// RULE9 - Clock-out counts at clock/2, 50% duty.
// RULE10 - Clock-out reloads on overflow, no interrupts; enabled direction-pin falls still set the external flag and interrupt.
// RULE11 - Output frequency clock/(4*(65536-reload)).
// RULE12 - Output clock drives the count pin.
// RULE13 - Software enables clock-out, then starts run.
// RULE14 - Baud and clock-out may share reload.
// RULE15 - Control register at C8h, fixed bit order.
// RULE16 - Baud clock bits force auto-reload.
// RULE17 - Direction pin fall with enable: capture/reload.
// RULE18 - Counter mode uses falling count-pin edges.
`ifndef TCU_TIMER_REGS_VH
`define TCU_TIMER_REGS_VH
`define TCU_ADDR_CTRL     8'hc8
`define TCU_ADDR_MODE     8'hcc
`define TCU_ADDR_CNT_LO   8'hd0
`define TCU_ADDR_CNT_HI   8'hd4
`define TCU_ADDR_REL_LO   8'hd8
`define TCU_ADDR_REL_HI   8'hdc
`define TCU_ADDR_IRQ_STAT 8'he0
`define TCU_ADDR_IRQ_EN   8'he4
`define TCU_ADDR_IRQ_CLR  8'he8
`define TCU_CTRL_OVF      7
`define TCU_CTRL_EXT      6
`define TCU_CTRL_RXCLK    5
`define TCU_CTRL_TXCLK    4
`define TCU_CTRL_EXTEN    3
`define TCU_CTRL_RUN      2
`define TCU_CTRL_CSEL     1
`define TCU_CTRL_CPRL     0
`define TCU_MODE_CLKOUT   1
`define TCU_MODE_UPDOWN   0
`define TCU_IRQ_OVF       0
`define TCU_IRQ_EXT       1
`define TCU_CTRL_RESET    8'h00
`define TCU_MODE_RESET    8'h00
`define TCU_CLK_MHZ       100
`define TCU_TIMER_DIV     12
`define TCU_CLKOUT_DIV    2
`endif

/* src/tcu_timer.v */
/*
 Holds the timer: APB register slave, count pin and direction pin
 conditioning, count engine and interrupt logic.
 Assumes pins asynchronous to sys_clk and an APB master on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcu_timer_regs.vh"
module tcu_timer (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rst_n,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Pins
   input  wire        countPinIn,
   output reg         countPinOut,
   output reg         countPinOe,
   input  wire        directionPin,
   // Events
   output reg         baudTick,
   output reg         irq
);
   // Reset release.
   reg  [1:0]  rstSync_r;
   wire        rstInt_n = rstSync_r[1];
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) rstSync_r <= 2'h0;
      else rstSync_r <= {rstSync_r[0], 1'b1};
   end

   // Registers.
   reg  [7:0]  ctrl_r;
   reg  [7:0]  mode_r;
   reg  [7:0]  cntLo_r;
   reg  [7:0]  cntHi_r;
   reg  [7:0]  relLo_r;
   reg  [7:0]  relHi_r;
   reg  [1:0]  irqStat_r;
   reg  [1:0]  irqEn_r;
   reg  [3:0]  preCnt_r;
   reg  [2:0]  cpSync_r;
   reg  [2:0]  dpSync_r;
   reg         cpFilt_r;
   reg         dpFilt_r;

   // Pin conditioning: the first stage feeds only the second, and a new level
   // is accepted once the second and third stages agree.
   always @(posedge sys_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         cpSync_r <= 3'h7;
         dpSync_r <= 3'h7;
         cpFilt_r <= 1'b1;
         dpFilt_r <= 1'b1;
      end else begin
         cpSync_r <= {cpSync_r[1:0], countPinIn};
         dpSync_r <= {dpSync_r[1:0], directionPin};
         if (cpSync_r[1] == cpSync_r[2]) cpFilt_r <= cpSync_r[2];
         if (dpSync_r[1] == dpSync_r[2]) dpFilt_r <= dpSync_r[2];
      end
   end
   wire cpFall = cpFilt_r & ~cpSync_r[2] & (cpSync_r[1] == cpSync_r[2]);
   wire dpFall = dpFilt_r & ~dpSync_r[2] & (dpSync_r[1] == dpSync_r[2]);

   // Mode decode.
   wire baudMode = ctrl_r[`TCU_CTRL_RXCLK] | ctrl_r[`TCU_CTRL_TXCLK];
   wire clkOut   = mode_r[`TCU_MODE_CLKOUT];
   wire capMode  = ctrl_r[`TCU_CTRL_CPRL] & ~baudMode;                       // RULE16
   wire upDown   = mode_r[`TCU_MODE_UPDOWN] & ~capMode & ~baudMode & ~clkOut; // RULE4 RULE5
   wire run      = ctrl_r[`TCU_CTRL_RUN];
   wire [15:0] cnt = {cntHi_r, cntLo_r};
   wire [15:0] rel = {relHi_r, relLo_r};

   // Count input: pin edges are ignored while the pin is driven as an output.
   // Wrap points of the prescaler, kept at its own width.
   localparam [3:0] PRE_TOP_CLKOUT = `TCU_CLKOUT_DIV - 1;
   localparam [3:0] PRE_TOP_TIMER  = `TCU_TIMER_DIV - 1;
   wire [3:0] preTop = clkOut ? PRE_TOP_CLKOUT : PRE_TOP_TIMER;             // RULE9
   wire preWrap = (preCnt_r == preTop);
   wire useClk = clkOut | ~ctrl_r[`TCU_CTRL_CSEL];                           // RULE2 RULE18
   wire tick = run & (useClk ? preWrap : cpFall);                            // RULE3 RULE18
   always @(posedge sys_clk or negedge rstInt_n) begin
      if (!rstInt_n) preCnt_r <= 4'h0;
      else if (!run || preWrap) preCnt_r <= 4'h0;
      else preCnt_r <= preCnt_r + 4'h1;
   end

   // Count engine.
   wire goDown  = upDown & ~dpFilt_r;                                        // RULE5
   wire loCarry = (cntLo_r == 8'hff);                                        // RULE1
   wire ovfUp   = tick & ~goDown & loCarry & (cntHi_r == 8'hff);             // RULE6
   wire ovfDn   = tick & goDown & (cnt == rel);                              // RULE7
   wire ovf     = ovfUp | ovfDn;
   wire extTrig = ctrl_r[`TCU_CTRL_EXTEN] & dpFall & ~baudMode & ~upDown;    // RULE17
   wire extReload = extTrig & ~capMode;
   wire extCap  = extTrig & capMode;
   wire tfSet   = ovf & ~baudMode & ~clkOut;                                 // RULE10 RULE16
   wire exfSet  = extTrig;
   wire exfTog  = ovf & upDown;                                              // RULE8

   // APB decode.
   wire apbAcc = psel & penable & pready;
   wire wrEn   = apbAcc & pwrite;
   wire wrCtrl = wrEn & (paddr == `TCU_ADDR_CTRL);
   wire wrCntLo = wrEn & (paddr == `TCU_ADDR_CNT_LO);
   wire wrCntHi = wrEn & (paddr == `TCU_ADDR_CNT_HI);
   wire wrRelLo = wrEn & (paddr == `TCU_ADDR_REL_LO);
   wire wrRelHi = wrEn & (paddr == `TCU_ADDR_REL_HI);

   reg  [15:0] cntNxt;
   always @* begin
      cntNxt = cnt;
      if (ovfUp || extReload) cntNxt = rel;                                  // RULE6 RULE10
      else if (ovfDn) cntNxt = 16'hffff;                                     // RULE7
      else if (tick && goDown) cntNxt = cnt - 16'h0001;
      else if (tick) cntNxt = {loCarry ? cntHi_r + 8'h01 : cntHi_r, cntLo_r + 8'h01}; // RULE1
   end

   always @(posedge sys_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         cntLo_r <= 8'h00;
         cntHi_r <= 8'h00;
         relLo_r <= 8'h00;
         relHi_r <= 8'h00;
      end else begin
         cntLo_r <= wrCntLo ? pwdata[7:0] : cntNxt[7:0];
         cntHi_r <= wrCntHi ? pwdata[7:0] : cntNxt[15:8];
         if (extCap) begin
            relLo_r <= cntLo_r;
            relHi_r <= cntHi_r;
         end else begin
            if (wrRelLo) relLo_r <= pwdata[7:0];                             // RULE14
            if (wrRelHi) relHi_r <= pwdata[7:0];
         end
      end
   end

   // Control and mode registers; a hardware flag event wins over a clear.
   reg  [7:0] ctrlNxt;
   always @* begin
      ctrlNxt = wrCtrl ? pwdata[7:0] : ctrl_r;                               // RULE15
      if (tfSet) ctrlNxt[`TCU_CTRL_OVF] = 1'b1;                              // RULE6
      if (exfSet) ctrlNxt[`TCU_CTRL_EXT] = 1'b1;                             // RULE17
      else if (exfTog) ctrlNxt[`TCU_CTRL_EXT] = ~ctrl_r[`TCU_CTRL_EXT];      // RULE8
   end
   always @(posedge sys_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         ctrl_r <= `TCU_CTRL_RESET;
         mode_r <= `TCU_MODE_RESET;
      end else begin
         ctrl_r <= ctrlNxt;
         if (wrEn && paddr == `TCU_ADDR_MODE) mode_r <= {6'h00, pwdata[1:0]};
      end
   end

   // Interrupt status: sticky, set wins over the write-one clear.
   wire [1:0] irqSet = {exfSet, tfSet};
   wire [1:0] irqClr = (wrEn && paddr == `TCU_ADDR_IRQ_CLR) ? pwdata[1:0] : 2'h0;
   always @(posedge sys_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         irqStat_r <= 2'h0;
         irqEn_r   <= 2'h0;
         irq       <= 1'b0;
      end else begin
         irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
         if (wrEn && paddr == `TCU_ADDR_IRQ_EN) irqEn_r <= pwdata[1:0];
         irq <= |(((irqStat_r & ~irqClr) | irqSet) & irqEn_r);
      end
   end

   // Clock output: toggling on each overflow at clock/2 gives clock/(4*(65536-reload)).
   always @(posedge sys_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         countPinOut <= 1'b0;
         countPinOe  <= 1'b0;
         baudTick    <= 1'b0;
      end else begin
         countPinOe <= clkOut;                                               // RULE12
         if (!clkOut) countPinOut <= 1'b0;
         else if (ovfUp) countPinOut <= ~countPinOut;                        // RULE9 RULE11 RULE12
         baudTick <= ovf & baudMode;                                         // RULE14
      end
   end

   // APB slave with one wait state so the read data leaves a flip-flop.
   reg [31:0] rdMux;
   reg        rdErr;
   always @* begin
      rdMux = 32'h0;
      rdErr = 1'b0;
      case (paddr)
         `TCU_ADDR_CTRL:     rdMux = {24'h0, ctrl_r};
         `TCU_ADDR_MODE:     rdMux = {24'h0, mode_r};
         `TCU_ADDR_CNT_LO:   rdMux = {24'h0, cntLo_r};
         `TCU_ADDR_CNT_HI:   rdMux = {24'h0, cntHi_r};
         `TCU_ADDR_REL_LO:   rdMux = {24'h0, relLo_r};
         `TCU_ADDR_REL_HI:   rdMux = {24'h0, relHi_r};
         `TCU_ADDR_IRQ_STAT: rdMux = {30'h0, irqStat_r};
         `TCU_ADDR_IRQ_EN:   rdMux = {30'h0, irqEn_r};
         `TCU_ADDR_IRQ_CLR:  rdMux = 32'h0;
         default:            rdErr = 1'b1;
      endcase
   end
   always @(posedge sys_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else if (psel && penable && !pready) begin
         pready  <= 1'b1;
         pslverr <= rdErr;
         prdata  <= pwrite ? 32'h0 : rdMux;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
   end
endmodule // tcu_timer
`default_nettype wire

/* dv/tcu_pin_model.sv */
/* Far side of the timer: count pin and direction pin.
 Assumes the bench commands pulses and the direction level. */
`timescale 1ns/1ps
`default_nettype none
module tcu_pin_model (
   // Clock
   input  wire logic sys_clk,
   // Pins
   input  wire logic countPinOut,
   input  wire logic countPinOe,
   output wire logic countPinIn,
   output wire logic directionPin
);
   logic drv = 1'b1;
   logic dir = 1'b1;
   // The wire follows the timer while it drives the pin.
   assign countPinIn   = countPinOe ? countPinOut : drv;
   assign directionPin = dir;
   // Each level holds four cycles, above the two the synchroniser needs.
   task automatic pulse(input int n);
      repeat (n) begin
         repeat (4) @(posedge sys_clk);
         drv <= 1'b0;
         repeat (4) @(posedge sys_clk);
         drv <= 1'b1;
      end
   endtask
endmodule // tcu_pin_model
`default_nettype wire

/* dv/tcu_timer_checker.sv */
/* Concurrent checks on the timer's ports.
 Assumes it is bound onto tcu_timer. */
`timescale 1ns/1ps
`default_nettype none
module tcu_timer_checker (
   // Clock and reset
   input wire logic        sys_clk, rst_n,
   // APB
   input wire logic        psel, penable, pwrite, pready, pslverr,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata, prdata,
   // Pins and events
   input wire logic        countPinOut, countPinOe, irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
   ready_phase_a: assert property (pready |-> psel && penable) else $error("pready outside access");
   ready_delay_a: assert property ($rose(penable) && psel |=> pready) else $error("pready late");
   err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
   unmapped_err_a: assert property (pready && paddr == 8'h00 |-> pslverr) else $error("no error");
   ctrl_mapped_a: assert property (pready && paddr == 8'hc8 |-> !pslverr) else $error("ctrl refused");
   irq_mask_a: assert property (pready && pwrite && paddr == 8'he4 && pwdata[1:0] == 2'h0 |-> ##2 !irq)
      else $error("irq not masked");
   pin_idle_a: assert property (!countPinOe |-> !countPinOut) else $error("pin driven");
   out_half_a: assert property ($changed(countPinOut) |=> $stable(countPinOut)) else $error("short half");
   c_err: cover property (pslverr);
   c_clk: cover property ($rose(countPinOut));
   c_irq: cover property ($rose(irq));
endmodule // tcu_timer_checker
bind tcu_timer tcu_timer_checker chk (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .countPinOut(countPinOut), .countPinOe(countPinOe), .irq(irq));
`default_nettype wire

/* dv/testbench.sv */
/* Self-checking bench of the timer.
 Assumes the pin model on the far side. */
`timescale 1ns/1ps
`default_nettype none
`include "tcu_timer_regs.vh"
module testbench;
   logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, v;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, countPinIn, countPinOut, countPinOe, directionPin, baudTick, irq;
   int failures = 0, checks = 0, cyc = 0, hi, per;
   tcu_timer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .countPinIn(countPinIn), .countPinOut(countPinOut), .countPinOe(countPinOe),
      .directionPin(directionPin), .baudTick(baudTick), .irq(irq));
   tcu_pin_model pins (.sys_clk(sys_clk), .countPinOut(countPinOut), .countPinOe(countPinOe),
      .countPinIn(countPinIn), .directionPin(directionPin));
   initial forever #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Holds the request until pready is sampled high, then releases at that edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) failures++;
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic load(input logic [15:0] r, input logic [15:0] c);
      apb(1, `TCU_ADDR_REL_LO, {24'h0, r[7:0]});
      apb(1, `TCU_ADDR_REL_HI, {24'h0, r[15:8]});
      apb(1, `TCU_ADDR_CNT_LO, {24'h0, c[7:0]});
      apb(1, `TCU_ADDR_CNT_HI, {24'h0, c[15:8]});
   endtask
   task automatic t_regs;
      rdchk(`TCU_ADDR_CTRL, 32'h0);
      apb(0, 8'h00, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1, `TCU_ADDR_CTRL, 32'h0a);
      rdchk(`TCU_ADDR_CTRL, 32'h0a);
      apb(1, `TCU_ADDR_CTRL, 32'h0);
   endtask
   task automatic t_timer;
      load(16'h0, 16'h0);
      apb(1, `TCU_ADDR_CTRL, 32'h04);
      repeat (120) @(posedge sys_clk);
      apb(1, `TCU_ADDR_CTRL, 32'h0);
      apb(0, `TCU_ADDR_CNT_LO, 32'h0);
      v = rd;
      chk(v >= 9 && v <= 12, 32'h1);
      rdchk(`TCU_ADDR_CNT_LO, v);
      load(16'h0, 16'h0);
      apb(1, `TCU_ADDR_CTRL, 32'h06);
      pins.pulse(5);
      apb(1, `TCU_ADDR_CTRL, 32'h0);
      rdchk(`TCU_ADDR_CNT_LO, 32'h5);
   endtask
   task automatic t_updown;
      apb(1, `TCU_ADDR_MODE, 32'h1);
      load(16'h1234, 16'hffff);
      apb(1, `TCU_ADDR_CTRL, 32'h04);
      repeat (30) @(posedge sys_clk);
      rdchk(`TCU_ADDR_CNT_HI, 32'h12);
      rdchk(`TCU_ADDR_CTRL, 32'hc4);
      rdchk(`TCU_ADDR_IRQ_STAT, 32'h1);
      apb(1, `TCU_ADDR_IRQ_EN, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk(irq, 32'h1);
      apb(1, `TCU_ADDR_IRQ_EN, 32'h0);
      repeat (2) @(posedge sys_clk);
      chk(irq, 32'h0);
      apb(1, `TCU_ADDR_CTRL, 32'h0);
      apb(1, `TCU_ADDR_IRQ_CLR, 32'h3);
      apb(1, `TCU_ADDR_IRQ_EN, 32'h1);
      rdchk(`TCU_ADDR_IRQ_STAT, 32'h0);
      pins.dir <= 1'b0;
      load(16'h1234, 16'h1235);
      apb(1, `TCU_ADDR_CTRL, 32'h04);
      repeat (30) @(posedge sys_clk);
      rdchk(`TCU_ADDR_CNT_HI, 32'hff);
      rdchk(`TCU_ADDR_CTRL, 32'hc4);
      apb(1, `TCU_ADDR_CTRL, 32'h0);
      apb(1, `TCU_ADDR_IRQ_CLR, 32'h3);
      pins.dir <= 1'b1;
   endtask
   task automatic t_clkout;
      apb(1, `TCU_ADDR_MODE, 32'h2);
      load(16'hfffe, 16'hfffe);
      apb(1, `TCU_ADDR_CTRL, 32'h04);
      chk(countPinOe, 32'h1);
      do begin @(posedge sys_clk); #1; end while (countPinOut !== 1'b1);
      hi = 0;
      do begin @(posedge sys_clk); #1; hi++; end while (countPinOut === 1'b1);
      per = hi;
      do begin @(posedge sys_clk); #1; per++; end while (countPinOut !== 1'b1);
      chk(hi, 32'h4);
      chk(per, 32'h8);
      rdchk(`TCU_ADDR_CTRL, 32'h04);
      chk(irq, 32'h0);
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1;
      repeat (3) @(posedge sys_clk);
      t_regs();
      t_timer();
      t_updown();
      t_clkout();
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
